// File: rtl/sfcmd_core.v
// Serial flash command decoder, sequencer and ready/busy timing
//
// Overview of operation
// R1: Accept either clock idle level at select
// R2: Sample serial input on clock rising edge
// R3: Idle-low suits mode 0, idle-high mode 3
// R4: Decode 68H and E8H as continuous read
// R5: Decode 52H and D2H as page read
// R6: Decode 54H and D4H as buffer read
// R7: Decode 57H and D7H as status read
// R8: Opcode then address; status read without address
// R9: Whole bytes, eight clocks, consecutive locations
// R10: Transfer or compare done within 200 us
// R11: Program and erase done within bounded times
// R12: Busy low within 200 ns of select rise
// R13: Host holds select high before reset release
// R14: Host sends reserved address bits as zero
// R15: Page written directly or via buffer
// R16: Host rewrites sector pages every 10,000 ops
// R17: Host rewrites using its page pointer
// R18: Sector decoded from upper page address bits
// R19: Address is 6 reserved, 9 page, 9 byte
// R20: Busy held low until operation completes
`timescale 1ns/10ps
`include "sfcmd_map.vh"
module sfcmd_core #(
	parameter CYC_XFR = `SFCMD_CYC_XFR,
	parameter CYC_EP = `SFCMD_CYC_EP,
	parameter CYC_P = `SFCMD_CYC_P,
	parameter CYC_PE = `SFCMD_CYC_PE,
	parameter CYC_BE = `SFCMD_CYC_BE
) (
	input wire ref_clk,
	input wire rstn,
	input wire csN,
	input wire sck,
	input wire si,
	output reg so,
	output reg soEn,
	output reg readyBusyN,
	output wire [1:0] sector,
	output wire [8:0] pageAddr,
	output wire [8:0] byteAddr,
	output wire rdValid,
	input wire rdReady,
	output wire [7:0] rdData,
	input wire [7:0] memData,
	output wire [7:0] opcode,
	output reg opStart
);
	////////////////////////////////////////////////////////////////
	// Command classes and sequencer states
	localparam CLS_NONE = 3'h0;
	localparam CLS_STAT = 3'h1;
	localparam CLS_ARRAY = 3'h2;
	localparam CLS_BUFRD = 3'h3;
	localparam CLS_WRITE = 3'h4;
	localparam CLS_TIMED = 3'h5;
	localparam ST_OPC = 2'h0;
	localparam ST_ADDR = 2'h1;
	localparam ST_DUMMY = 2'h2;
	localparam ST_DATA = 2'h3;
	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;
	// Don't-care byte counts, cut to the counter's width where used
	localparam DUMMY_ARRAY = `SFCMD_DUMMY_ARRAY;
	localparam DUMMY_BUF = `SFCMD_DUMMY_BUF;

	// Opcode class lookup, used for the opcode byte and the launch
	function [2:0] opClass;
		input [7:0] op;
		begin
			case (op)
				`SFCMD_OP_STAT_POL, `SFCMD_OP_STAT_SPI: opClass = CLS_STAT; // R7
				`SFCMD_OP_CAR_POL, `SFCMD_OP_CAR_SPI,
				`SFCMD_OP_PGRD_POL, `SFCMD_OP_PGRD_SPI: opClass = CLS_ARRAY; // R4 R5
				`SFCMD_OP_BUFRD_POL, `SFCMD_OP_BUFRD_SPI: opClass = CLS_BUFRD; // R6
				`SFCMD_OP_BUFWR: opClass = CLS_WRITE; // R15
				`SFCMD_OP_PROG_ERASE, `SFCMD_OP_PROG_ONLY, `SFCMD_OP_PAGE_ERASE,
				`SFCMD_OP_BLOCK_ERASE, `SFCMD_OP_XFER, `SFCMD_OP_CMP,
				`SFCMD_OP_REWRITE: opClass = CLS_TIMED;
				`SFCMD_OP_PROG_THRU: opClass = CLS_TIMED; // R15
				default: opClass = CLS_NONE;
			endcase
		end
	endfunction

	// Self-timed duration of a launched command, in clock cycles
	function [31:0] opCycles;
		input [7:0] op;
		begin
			case (op)
				`SFCMD_OP_XFER, `SFCMD_OP_CMP: opCycles = CYC_XFR; // R10
				`SFCMD_OP_PROG_ERASE, `SFCMD_OP_PROG_THRU,
				`SFCMD_OP_REWRITE: opCycles = CYC_EP; // R11
				`SFCMD_OP_PROG_ONLY: opCycles = CYC_P; // R11
				`SFCMD_OP_PAGE_ERASE: opCycles = CYC_PE; // R11
				`SFCMD_OP_BLOCK_ERASE: opCycles = CYC_BE; // R11
				default: opCycles = 32'h1;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Pin synchronisers; select idles high so its stages reset high
	wire csLvl, csRise, csFall;
	wire sckRise, sckFall;
	wire siLvl;
	sfcmd_sync #(.RESET_VAL(1'b1)) uCs (.ref_clk(ref_clk), .rstn(rstn), .async(csN),
		.level(csLvl), .rise(csRise), .fall(csFall));
	sfcmd_sync #(.RESET_VAL(1'b0)) uSck (.ref_clk(ref_clk), .rstn(rstn), .async(sck),
		.level(), .rise(sckRise), .fall(sckFall));
	sfcmd_sync #(.RESET_VAL(1'b0)) uSi (.ref_clk(ref_clk), .rstn(rstn), .async(si),
		.level(siLvl), .rise(), .fall());

	////////////////////////////////////////////////////////////////
	// Shift state
	reg [1:0] phase_r; // Command phase
	reg [2:0] bitCnt_r; // Bit within the current byte
	reg [7:0] shiftIn_r; // Incoming byte
	reg [7:0] opcode_r; // Latched opcode
	reg [2:0] cls_r; // Latched class
	reg [23:0] addr_r; // Address word, MSB first
	reg [1:0] addrCnt_r; // Address bytes seen
	reg [2:0] dummyCnt_r; // Don't-care bytes left
	reg [7:0] shiftOut_r; // Outgoing byte
	reg busyState_r; // Self-timed operation running
	reg [31:0] timer_r; // Cycles left in the operation
	reg pendLaunch_r; // Launch waiting for select rise
	reg fetch_r; // Request a word into the buffer
	wire [7:0] nextByte = {shiftIn_r[6:0], siLvl};
	wire byteDone = sckRise & (bitCnt_r == 3'h7) & ~csLvl;
	wire [7:0] statusByte = {readyBusyN, 7'h00};
	wire fifoOutValid;
	wire [7:0] fifoOutData;
	wire fifoInReady;
	wire fifoPop;

	assign opcode = opcode_r;
	assign pageAddr = addr_r[`SFCMD_PA_HI:`SFCMD_PA_LO]; // R19
	assign byteAddr = addr_r[`SFCMD_BA_HI:`SFCMD_BA_LO]; // R19
	// Upper six page bits pick the sector; low page bits ignored
	assign sector = pageAddr[8] ? 2'h2 : (pageAddr[8:3] == 6'h00 ? 2'h0 : 2'h1); // R18

	////////////////////////////////////////////////////////////////
	// Buffer between memory fetch and the serial shifter
	sfcmd_skid #(.WIDTH(8)) uBuf (.ref_clk(ref_clk), .rstn(rstn),
		.inValid(fetch_r), .inReady(fifoInReady), .inData(memData),
		.outValid(fifoOutValid), .outReady(fifoPop), .outData(fifoOutData));
	// Shifter takes a word at each data-phase byte boundary, except in status reads and buffer writes
	assign fifoPop = byteDone & (phase_r == ST_DATA) & (cls_r != CLS_STAT)
		& (cls_r != CLS_WRITE);
	assign rdValid = fifoOutValid;
	assign rdData = fifoOutData;

	////////////////////////////////////////////////////////////////
	// Command shifter: bits on rising edge, whole bytes only
	always @(posedge ref_clk) begin
		if (!rstn) begin
			phase_r <= ST_OPC;
			bitCnt_r <= 3'h0;
			shiftIn_r <= 8'h00;
			opcode_r <= 8'h00;
			cls_r <= CLS_NONE;
			addr_r <= 24'h000000;
			addrCnt_r <= 2'h0;
			dummyCnt_r <= 3'h0;
			fetch_r <= 1'b0;
			pendLaunch_r <= 1'b0;
		end else begin
			fetch_r <= 1'b0;
			if (csFall) begin
				// Either clock level is fine here; only rising edges count
				phase_r <= ST_OPC; // R1 R3
				bitCnt_r <= 3'h0;
				addrCnt_r <= 2'h0;
				pendLaunch_r <= 1'b0;
			end else if (csRise) begin
				pendLaunch_r <= 1'b0;
			end else if (sckRise && !csLvl) begin
				shiftIn_r <= nextByte; // R2
				bitCnt_r <= bitCnt_r + 3'h1; // R9
				if (bitCnt_r == 3'h7) begin
					case (phase_r)
						ST_OPC: begin
							opcode_r <= nextByte;
							cls_r <= opClass(nextByte);
							// Status read has no address bytes
							if (opClass(nextByte) == CLS_STAT) begin // R8
								phase_r <= ST_DATA;
							end else begin
								phase_r <= ST_ADDR; // R8
							end
						end
						ST_ADDR: begin
							addr_r <= {addr_r[15:0], nextByte}; // R19
							addrCnt_r <= addrCnt_r + 2'h1;
							if (addrCnt_r == 2'h2) begin
								if (cls_r == CLS_ARRAY) begin
									phase_r <= ST_DUMMY;
									dummyCnt_r <= DUMMY_ARRAY[2:0];
								end else if (cls_r == CLS_BUFRD) begin
									phase_r <= ST_DUMMY;
									dummyCnt_r <= DUMMY_BUF[2:0];
								end else begin
									phase_r <= ST_DATA;
									pendLaunch_r <= (cls_r == CLS_TIMED);
								end
							end
						end
						ST_DUMMY: begin
							dummyCnt_r <= dummyCnt_r - 3'h1;
							if (dummyCnt_r == 3'h1)
								phase_r <= ST_DATA;
						end
						default: begin
							// Next byte from the next location
							if (cls_r != CLS_STAT)
								addr_r[8:0] <= addr_r[8:0] + 9'h001; // R9
						end
					endcase
				end
			end
			// Prefetch one word ahead of the shifter
			if (phase_r != ST_OPC && phase_r != ST_ADDR && fifoInReady && !fetch_r
				&& (cls_r == CLS_ARRAY || cls_r == CLS_BUFRD) && !fifoOutValid)
				fetch_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Output shifter: changes on falling edge, MSB first
	always @(posedge ref_clk) begin
		if (!rstn) begin
			shiftOut_r <= 8'h00;
			so <= 1'b0;
			soEn <= 1'b0;
		end else begin
			// Phase still shows the last frame at select fall; keep the pin off then
			soEn <= ~csLvl & ~csFall & (phase_r == ST_DATA) & (cls_r != CLS_WRITE)
				& (cls_r != CLS_TIMED) & (cls_r != CLS_NONE);
			if (byteDone && (phase_r == ST_DATA || (phase_r == ST_OPC
				&& opClass(nextByte) == CLS_STAT)
				|| (phase_r == ST_DUMMY && dummyCnt_r == 3'h1))) begin
				shiftOut_r <= (cls_r == CLS_STAT || phase_r == ST_OPC) ? statusByte // R7
					: fifoOutData;
			end else if (sckFall) begin
				so <= shiftOut_r[7];
				shiftOut_r <= {shiftOut_r[6:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Self-timed operation: busy starts on select rise, ends by timer
	always @(posedge ref_clk) begin
		if (!rstn) begin
			busyState_r <= ST_IDLE;
			timer_r <= 32'h0;
			readyBusyN <= 1'b1;
			opStart <= 1'b0;
		end else begin
			opStart <= 1'b0;
			case (busyState_r)
				ST_IDLE: begin
					if (csRise && pendLaunch_r) begin
						// Synchroniser delay is 3 cycles, inside the 200 ns bound
						readyBusyN <= 1'b0; // R12
						opStart <= 1'b1;
						timer_r <= opCycles(opcode_r);
						busyState_r <= ST_BUSY;
					end
				end
				default: begin
					if (timer_r <= 32'h1) begin
						readyBusyN <= 1'b1; // R20
						busyState_r <= ST_IDLE;
					end else begin
						timer_r <= timer_r - 32'h1; // R10 R11 R20
					end
				end
			endcase
		end
	end
endmodule // sfcmd_core

// File: rtl/sfcmd_skid.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module sfcmd_skid #(
	parameter WIDTH = 8
) (
	input wire ref_clk,
	input wire rstn,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output reg [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] spare_r; // Second slot, used only while stalled
	reg [1:0] count_r; // Words held, 0 to 2
	wire pushW = inValid & inReady;
	wire popW = outValid & outReady;
	assign inReady = (count_r != 2'h2);
	assign outValid = (count_r != 2'h0);
	////////////////////////////////////////////////////////////////
	// Head is outData; spare moves up on a pop
	always @(posedge ref_clk) begin
		if (!rstn) begin
			count_r <= 2'h0;
			outData <= {WIDTH{1'b0}};
			spare_r <= {WIDTH{1'b0}};
		end else begin
			count_r <= count_r + {1'b0, pushW} - {1'b0, popW};
			if (popW) begin
				// Refill head from spare or from the new word
				if (count_r == 2'h2)
					outData <= spare_r;
				else if (pushW)
					outData <= inData;
			end else if (pushW) begin
				if (count_r == 2'h0)
					outData <= inData;
				else
					spare_r <= inData;
			end
			if (popW && pushW && count_r == 2'h2)
				spare_r <= inData;
		end
	end
endmodule // sfcmd_skid

// File: rtl/sfcmd_sync.v
// Two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/10ps
module sfcmd_sync #(
	parameter RESET_VAL = 1'b0
) (
	input wire ref_clk,
	input wire rstn,
	input wire async,
	output reg level,
	output wire rise,
	output wire fall
);
	reg meta_r; // First stage, read only by the second
	reg prev_r; // Previous synchronised level
	////////////////////////////////////////////////////////////////
	// Two stages then one delay for the edge detectors
	always @(posedge ref_clk) begin
		if (!rstn) begin
			meta_r <= RESET_VAL;
			level <= RESET_VAL;
			prev_r <= RESET_VAL;
		end else begin
			meta_r <= async;
			level <= meta_r;
			prev_r <= level;
		end
	end
	assign rise = level & ~prev_r;
	assign fall = ~level & prev_r;
endmodule // sfcmd_sync

// File: shared/sfcmd_map.vh
// Opcodes, address layout and timing constants of the serial flash command sequencer
`ifndef SFCMD_MAP_VH
`define SFCMD_MAP_VH
// Read opcodes, clock-polarity forms
`define SFCMD_OP_CAR_POL 8'h68
`define SFCMD_OP_PGRD_POL 8'h52
`define SFCMD_OP_BUFRD_POL 8'h54
`define SFCMD_OP_STAT_POL 8'h57
// Read opcodes, SPI-mode forms
`define SFCMD_OP_CAR_SPI 8'he8
`define SFCMD_OP_PGRD_SPI 8'hd2
`define SFCMD_OP_BUFRD_SPI 8'hd4
`define SFCMD_OP_STAT_SPI 8'hd7
// Program, erase and transfer opcodes
`define SFCMD_OP_BUFWR 8'h84
`define SFCMD_OP_PROG_ERASE 8'h83
`define SFCMD_OP_PROG_ONLY 8'h88
`define SFCMD_OP_PAGE_ERASE 8'h81
`define SFCMD_OP_BLOCK_ERASE 8'h50
`define SFCMD_OP_PROG_THRU 8'h82
`define SFCMD_OP_XFER 8'h53
`define SFCMD_OP_CMP 8'h60
`define SFCMD_OP_REWRITE 8'h58
// Address field positions in the 24-bit address word
`define SFCMD_PA_HI 17
`define SFCMD_PA_LO 9
`define SFCMD_BA_HI 8
`define SFCMD_BA_LO 0
// Don't-care bytes after the address
`define SFCMD_DUMMY_ARRAY 4
`define SFCMD_DUMMY_BUF 1
// Clock rate and operation limits
`define SFCMD_CLK_MHZ 20
`define SFCMD_T_XFR_US 200
`define SFCMD_T_EP_MS 20
`define SFCMD_T_P_MS 15
`define SFCMD_T_PE_MS 10
`define SFCMD_T_BE_MS 15
`define SFCMD_T_CSB_NS 200
`define SFCMD_CYC_XFR (`SFCMD_T_XFR_US * `SFCMD_CLK_MHZ)
`define SFCMD_CYC_EP (`SFCMD_T_EP_MS * 1000 * `SFCMD_CLK_MHZ)
`define SFCMD_CYC_P (`SFCMD_T_P_MS * 1000 * `SFCMD_CLK_MHZ)
`define SFCMD_CYC_PE (`SFCMD_T_PE_MS * 1000 * `SFCMD_CLK_MHZ)
`define SFCMD_CYC_BE (`SFCMD_T_BE_MS * 1000 * `SFCMD_CLK_MHZ)
`define SFCMD_CYC_CSB ((`SFCMD_T_CSB_NS * `SFCMD_CLK_MHZ) / 1000)
`endif

// File: verif/sfcmd_core_sva.sv
// Concurrent checks on the sequencer's busy, launch and decode ports
`timescale 1ns/10ps
module sfcmd_core_sva #(
	parameter CYC_XFR = 20,
	parameter CYC_EP = 20,
	parameter CYC_P = 20,
	parameter CYC_PE = 20,
	parameter CYC_BE = 20
) (
	input wire ref_clk,
	input wire rstn,
	input wire csN,
	input wire soEn,
	input wire readyBusyN,
	input wire [1:0] sector,
	input wire [8:0] pageAddr,
	input wire [7:0] opcode,
	input wire opStart
);
	reg [31:0] busyCnt_r; // Cycles spent busy so far
	reg [31:0] lim_r; // Busy span of the launched command
	// Busy span of a command; zero where it never goes busy
	function automatic [31:0] limOf(input [7:0] op);
		case (op)
			8'h53, 8'h60: limOf = CYC_XFR;
			8'h82, 8'h83, 8'h58: limOf = CYC_EP;
			8'h88: limOf = CYC_P;
			8'h81: limOf = CYC_PE;
			8'h50: limOf = CYC_BE;
			default: limOf = 32'h0;
		endcase
	endfunction
	// Read opcodes of all clocking forms
	function automatic isRead(input [7:0] op);
		isRead = op inside {8'h68, 8'he8, 8'h52, 8'hd2, 8'h54, 8'hd4, 8'h57, 8'hd7};
	endfunction
	//////////////////////////////////////////////////
	// Span latched at launch: a status read may change opcode mid-busy
	always @(posedge ref_clk) begin
		if (!rstn) begin
			busyCnt_r <= 32'h0;
			lim_r <= 32'h0;
		end else begin
			busyCnt_r <= readyBusyN ? 32'h0 : busyCnt_r + 32'h1;
			if (opStart) begin
				lim_r <= limOf(opcode);
			end
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence sLaunch;
		$rose(csN) && limOf(opcode) != 32'h0;
	endsequence
	sequence sBusyHeld;
		!readyBusyN [*8];
	endsequence
	AST_BUSY_DELAY: assert property (sLaunch |-> ##[1:4] !readyBusyN)
		else $error("busy late after select rise");
	AST_START_BUSY: assert property (opStart |-> ##[0:1] sBusyHeld)
		else $error("launch without held busy");
	AST_START_PULSE: assert property (opStart |=> !opStart)
		else $error("launch pulse too long");
	AST_READ_IDLE: assert property ($rose(csN) && readyBusyN && isRead(opcode) |=> readyBusyN [*6])
		else $error("read command went busy");
	AST_SECTOR: assert property (sector == (pageAddr[8] ? 2'h2 : (|pageAddr[7:3] ? 2'h1 : 2'h0)))
		else $error("sector decode wrong");
	AST_BUSY_MAX: assert property (!readyBusyN |-> busyCnt_r <= lim_r + 32'h4)
		else $error("busy too long");
	AST_BUSY_MIN: assert property ($rose(readyBusyN) |-> busyCnt_r + 32'h2 >= lim_r)
		else $error("busy ended early");
	AST_OUT_OFF: assert property ($rose(csN) |-> ##[1:5] !soEn)
		else $error("output still driven after deselect");
	AST_NO_DRIVE: assert property (soEn |-> limOf(opcode) == 32'h0)
		else $error("output driven for a timed command");
endmodule // sfcmd_core_sva
bind sfcmd_core sfcmd_core_sva #(.CYC_XFR(CYC_XFR), .CYC_EP(CYC_EP), .CYC_P(CYC_P),
	.CYC_PE(CYC_PE), .CYC_BE(CYC_BE)) chkU (.ref_clk(ref_clk), .rstn(rstn), .csN(csN),
	.soEn(soEn), .readyBusyN(readyBusyN), .sector(sector), .pageAddr(pageAddr),
	.opcode(opcode), .opStart(opStart));

// File: verif/sfcmd_host_model.sv
// Host controller model driving select, clock and serial input
`timescale 1ns/10ps
module sfcmd_host_model (
	input wire ref_clk,
	output logic csN,
	output logic sck,
	output logic si,
	input wire so,
	input wire soEn
);
	// Pulled up while the device does not drive
	wire soLine = soEn ? so : 1'b1;
	// Select high from time zero, across reset release
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// Half a clock period; slow enough for the two-flop sampler
	task automatic halfWait();
		repeat (8) @(negedge ref_clk);
	endtask
	// Select with the clock parked at either idle level
	task automatic frameOpen(input logic pol);
		@(negedge ref_clk);
		sck = pol;
		halfWait();
		csN = 1'b0;
		halfWait();
	endtask
	// MSB first; data moves while low, device samples on the rise
	task automatic xferByte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			halfWait();
			sck = 1'b1;
			rx[i] = soLine;
			halfWait();
		end
	endtask
	// Park clock, flip the released data line, deselect
	task automatic frameClose(input logic pol);
		sck = pol;
		si = ~si;
		halfWait();
		csN = 1'b1;
		halfWait();
	endtask
endmodule // sfcmd_host_model

// File: verif/tb_top.sv
// Self-checking bench of the serial flash command sequencer
`timescale 1ns/10ps
module tb_top;
	localparam int XFR = 20, EP = 44, P = 36, PE = 28, BE = 600;
	typedef struct {logic [7:0] op; logic [8:0] pg; logic pol; logic [1:0] sec; int cyc;} sfcmd_row_t;
	logic ref_clk = 1'b0, rstn = 1'b0, rdReady = 1'b1;
	logic [7:0] memData = 8'h3c, rx;
	logic [8:0] refreshPtr = 9'h1fe; // Host's next page to refresh
	wire csN, sck, si, so, soEn, readyBusyN, opStart, rdValid;
	wire [1:0] sector;
	wire [8:0] pageAddr, byteAddr;
	wire [7:0] opcode, rdData;
	int fail_count = 0, checks = 0, lowCnt = 0, lastLow = 0, starts = 0, s0;
	// Timed commands, then reads and a buffer write
	sfcmd_row_t rows [18] = '{'{8'h81, 9'h007, 0, 0, PE}, '{8'h50, 9'h008, 1, 1, BE},
		'{8'h83, 9'h0ff, 0, 1, EP}, '{8'h88, 9'h100, 1, 2, P}, '{8'h82, 9'h1ff, 0, 2, EP},
		'{8'h58, 9'h0a5, 1, 1, EP}, '{8'h53, 9'h000, 0, 0, XFR}, '{8'h60, 9'h13c, 1, 2, XFR},
		'{8'h68, 9'h001, 0, 0, 0}, '{8'he8, 9'h055, 1, 1, 0}, '{8'h52, 9'h155, 0, 2, 0},
		'{8'hd2, 9'h0f0, 1, 1, 0}, '{8'h54, 0, 0, 0, 0}, '{8'hd4, 0, 1, 0, 0},
		'{8'h84, 0, 0, 0, 0}, '{8'h57, 0, 1, 0, 0}, '{8'hd7, 0, 0, 0, 0}, '{8'h68, 9'h1c3, 1, 2, 0}};
	always #25 ref_clk = ~ref_clk;
	// Toggle pattern on rdReady, an input the core leaves unused
	always @(negedge ref_clk) rdReady <= ~rdReady;
	sfcmd_host_model hostU (.ref_clk(ref_clk), .csN(csN), .sck(sck), .si(si), .so(so), .soEn(soEn));
	sfcmd_core #(.CYC_XFR(XFR), .CYC_EP(EP), .CYC_P(P), .CYC_PE(PE), .CYC_BE(BE)) dut_u (
		.ref_clk(ref_clk), .rstn(rstn), .csN(csN), .sck(sck), .si(si), .so(so), .soEn(soEn),
		.readyBusyN(readyBusyN), .sector(sector), .pageAddr(pageAddr), .byteAddr(byteAddr),
		.rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .memData(memData), .opcode(opcode),
		.opStart(opStart));
	//////////////////////////////////////////////////
	// Busy span and launch count seen at the pins
	always @(posedge ref_clk) begin
		if (opStart === 1'b1) starts <= starts + 1;
		if (readyBusyN === 1'b0) lowCnt <= lowCnt + 1;
		else if (lowCnt != 0) begin
			lastLow <= lowCnt;
			lowCnt <= 0;
		end
	end
	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Busy span with one cycle of slack for the synchroniser
	task automatic chkNear(input int got, input int exp);
		checks++;
		if (got < exp - 1 || got > exp + 1) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One frame: opcode, address unless status, dummies, one data byte for reads only
	task automatic runCmd(input logic [7:0] op, input logic [8:0] pg, input logic pol);
		hostU.frameOpen(pol);
		hostU.xferByte(op, rx);
		if (!(op inside {8'h57, 8'hd7})) begin
			hostU.xferByte({6'h00, pg[8:7]}, rx);
			hostU.xferByte({pg[6:0], 1'b1}, rx);
			hostU.xferByte(8'ha5, rx);
		end
		repeat (op inside {8'h68, 8'he8, 8'h52, 8'hd2} ? 4 : op inside {8'h54, 8'hd4})
			hostU.xferByte(8'h00, rx);
		if (op inside {8'h68, 8'he8, 8'h52, 8'hd2, 8'h54, 8'hd4, 8'h57, 8'hd7})
			hostU.xferByte(8'h00, rx);
		hostU.frameClose(pol);
	endtask
	task automatic waitReady();
		for (int n = 0; n < 2000 && readyBusyN !== 1'b1; n++) @(negedge ref_clk);
		repeat (3) @(negedge ref_clk);
	endtask
	initial begin
		repeat (16) @(negedge ref_clk);
		chkVal({readyBusyN, soEn, opStart}, 3'b100);
		rstn = 1'b1;
		repeat (4) @(negedge ref_clk);
		for (int i = 0; i < 18; i++) begin
			lastLow = 0;
			s0 = starts;
			runCmd(rows[i].op, rows[i].pg, rows[i].pol);
			waitReady();
			chkVal(opcode, rows[i].op);
			if (rows[i].pg != 0 || rows[i].op inside {8'h53}) chkVal(pageAddr, rows[i].pg);
			chkVal(sector, rows[i].sec);
			// Byte address sent is 1a5; one data byte read moves it on by one
			if (!(rows[i].op inside {8'h57, 8'hd7}))
				chkVal(byteAddr, 9'h1a5 + (rows[i].cyc == 0 && rows[i].op != 8'h84));
			// Buffer is refilled once the shifter has taken its word
			if (rows[i].cyc == 0 && !(rows[i].op inside {8'h84, 8'h57, 8'hd7}))
				chkVal({rdValid, rdData}, {1'b1, memData});
			if (rows[i].op inside {8'h57, 8'hd7}) chkVal(rx, 8'h80);
			else if (rows[i].cyc == 0 && rows[i].op != 8'h84) chkVal(rx, memData);
			chkNear(lastLow, rows[i].cyc);
			chkVal(starts - s0, rows[i].cyc != 0);
			$display("test %0d done", i);
		end
		// Unknown opcode launches nothing; status reports busy mid-erase
		s0 = starts;
		runCmd(8'h00, 9'h000, 1'b1);
		waitReady();
		chkVal(starts - s0, 0);
		runCmd(8'h50, 9'h100, 1'b0);
		runCmd(8'hd7, 9'h000, 1'b1);
		chkVal(rx, 8'h00);
		waitReady();
		runCmd(8'h57, 9'h000, 1'b0);
		chkVal(rx, 8'h80);
		$display("test status while busy done");
		// Refresh bookkeeping: rewrite the page the pointer names, then step it
		for (int k = 0; k < 2; k++) begin
			lastLow = 0;
			runCmd(8'h58, refreshPtr, k[0]);
			waitReady();
			chkVal(pageAddr, refreshPtr);
			chkNear(lastLow, EP);
			refreshPtr = refreshPtr + 9'h001;
		end
		$display("test page refresh done");
		// Reset in mid-erase returns the device to ready
		runCmd(8'h81, 9'h000, 1'b0);
		rstn = 1'b0;
		repeat (16) @(negedge ref_clk);
		chkVal({readyBusyN, soEn, opStart}, 3'b100);
		rstn = 1'b1;
		repeat (4) @(negedge ref_clk);
		lastLow = 0;
		runCmd(8'h88, 9'h0c0, 1'b1);
		waitReady();
		chkNear(lastLow, P);
		$display("test reset mid-operation done");
		conclude();
	end
	initial begin
		#(80000 * 50);
		fail_count++;
		conclude();
	end
endmodule // tb_top
